// ### src/sdwp_params.svh
// Constants for the SDRAM write and precharge path.
`ifndef SDWP_PARAMS_SVH
`define SDWP_PARAMS_SVH
`define SDWP_CK_NS      20
`define SDWP_WR_NS      15
`define SDWP_RP_NS      20
`define SDWP_MASK_NS    15
`define SDWP_WR_CYC     ((`SDWP_WR_NS + `SDWP_CK_NS - 1) / `SDWP_CK_NS)
`define SDWP_RP_CYC     ((`SDWP_RP_NS + `SDWP_CK_NS - 1) / `SDWP_CK_NS)
`define SDWP_MASK_NEED  (`SDWP_CK_NS < `SDWP_MASK_NS)
`define SDWP_AP_WAIT    8
`define SDWP_CMD_ACT    3'h3
`define SDWP_CMD_READ   3'h5
`define SDWP_CMD_WRITE  3'h4
`define SDWP_CMD_TERM   3'h6
`define SDWP_CMD_PRE    3'h2
`define SDWP_CMD_MODE   3'h0
`define SDWP_CMD_NOP    3'h7
`define SDWP_BL_LSB     0
`define SDWP_BL_MSB     2
`define SDWP_WBM_BIT    9
`define SDWP_AP_BIT     10
`define SDWP_BL_FULL    3'h7
`define SDWP_DQ_W       16
`define SDWP_COL_W      9
`define SDWP_ROW_W      12
`define SDWP_FIFO_W     39
`define SDWP_FIFO_D     4
`endif

// ### src/sdwp_pkg.sv
// Types used by the controller end and the bench of the SDRAM write and precharge path.
package sdwp_pkg;
    typedef enum logic [2:0] {
        SDWP_OP_ACT,
        SDWP_OP_WRITE,
        SDWP_OP_READ,
        SDWP_OP_PRE,
        SDWP_OP_TERM,
        SDWP_OP_MODE
    } sdwp_op_t;
endpackage : sdwp_pkg

// ### src/sdwp_link_if.sv
// Pin-level link between the memory controller and the SDRAM.
interface sdwp_link_if (
    input wire logic clk
);
    logic        cs_n;
    logic [2:0]  cmd_n;
    logic [11:0] addr;
    logic        bank_select_lo;
    logic        bank_select_hi;
    logic        dqm;
    logic [15:0] dq_host_out;
    logic        dq_host_oe_n;
    logic [15:0] dq_dev_out;
    logic        dq_dev_oe_n;
    logic [15:0] dq;

    // Resolved data wire; an undriven bus reads as zero.
    assign dq = !dq_host_oe_n ? dq_host_out : (!dq_dev_oe_n ? dq_dev_out : 16'h0000);

    modport host (
        input  clk, dq,
        output cs_n, cmd_n, addr, bank_select_lo, bank_select_hi, dqm,
        output dq_host_out, dq_host_oe_n
    );
    modport dev (
        input  clk, cs_n, cmd_n, addr, bank_select_lo, bank_select_hi, dqm, dq,
        output dq_dev_out, dq_dev_oe_n
    );
endinterface : sdwp_link_if

// ### src/sdwp_fifo.sv
// Small shift-register FIFO whose head sits in a flip-flop.
module sdwp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [$clog2(DEPTH+1)-1:0]  cnt;
        logic                        nonempty;
        logic                        notfull;
    } sdwp_fifo_st_t;

    sdwp_fifo_st_t st_reg;
    sdwp_fifo_st_t st_next;
    logic          pop;
    logic          push;

    assign in_ready  = st_reg.notfull;
    assign out_valid = st_reg.nonempty;
    assign out_data  = st_reg.mem[0];

    always_comb begin
        st_next = st_reg;
        pop     = st_reg.nonempty && out_ready;
        push    = in_valid && st_reg.notfull;
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                st_next.mem[i] = st_reg.mem[i+1];
            end
        end
        if (push) begin
            st_next.mem[st_reg.cnt - $bits(st_reg.cnt)'(pop)] = in_data;
        end
        st_next.cnt      = st_reg.cnt + $bits(st_reg.cnt)'(push) - $bits(st_reg.cnt)'(pop);
        st_next.nonempty = st_next.cnt != '0;
        st_next.notfull  = st_next.cnt != $bits(st_reg.cnt)'(DEPTH);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg         <= '0;
            st_reg.notfull <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule : sdwp_fifo

// ### src/sdwp_dev.sv
// SDRAM end: write bursts, truncation, masking and precharge.
`include "sdwp_params.svh"
module sdwp_dev (
    input  wire logic                    clk,
    input  wire logic                    rst,
    sdwp_link_if.dev                     link,
    output logic                         store_valid,
    input  wire logic                    store_ready,
    output logic [`SDWP_FIFO_W-1:0]      store_word,
    output logic [3:0]                   bank_open,
    output logic                         burst_busy,
    output logic                         store_dropped
);
    typedef struct packed {
        logic [2:0]                       bl;
        logic                             wbm;
        logic [3:0]                       open;
        logic [3:0][`SDWP_ROW_W-1:0]      row;
        logic                             act;
        logic                             full;
        logic                             ap;
        logic [1:0]                       bank;
        logic [`SDWP_COL_W-1:0]           col;
        logic [`SDWP_COL_W:0]             left;
        logic                             ap_run;
        logic [1:0]                       ap_bank;
        logic [3:0]                       ap_cnt;
        logic                             drop;
    } sdwp_dev_st_t;

    sdwp_dev_st_t                 st_reg;
    sdwp_dev_st_t                 st_next;
    logic                         push;
    logic [`SDWP_FIFO_W-1:0]      push_word;
    logic                         fifo_ready;
    logic [2:0]                   cmd;
    logic [1:0]                   ba;
    logic                         ap_start;
    logic [1:0]                   ap_start_bank;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [`SDWP_COL_W:0] burst_len(input logic [2:0] bl);
        burst_len = (`SDWP_COL_W+1)'(1) << bl;
    endfunction : burst_len

    // Sequential order inside the burst block; a full page wraps at its end.
    function automatic logic [`SDWP_COL_W-1:0] next_col(
        input logic [`SDWP_COL_W-1:0] col,
        input logic [2:0]             bl,
        input logic                   full
    );
        logic [`SDWP_COL_W-1:0] mask;
        mask = `SDWP_COL_W'(burst_len(bl) - 1'b1);
        if (full) begin
            next_col = col + 1'b1;
        end else begin
            next_col = (col & ~mask) | ((col + 1'b1) & mask);
        end
    endfunction : next_col

    // ------------------------------------------------------------------
    // Link decode and write-data buffer
    // ------------------------------------------------------------------
    assign cmd = link.cs_n ? `SDWP_CMD_NOP : link.cmd_n;
    assign ba  = {link.bank_select_hi, link.bank_select_lo};

    assign link.dq_dev_out  = '0;
    assign link.dq_dev_oe_n = 1'b1;
    assign bank_open        = st_reg.open;
    assign burst_busy       = st_reg.act;
    assign store_dropped    = st_reg.drop;

    // A full buffer cannot stall the link, so the element is lost and flagged.
    sdwp_fifo #(
        .WIDTH (`SDWP_FIFO_W),
        .DEPTH (`SDWP_FIFO_D)
    ) sdwp_fifo_inst (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .in_data   (push_word),
        .out_valid (store_valid),
        .out_ready (store_ready),
        .out_data  (store_word)
    );

    // ------------------------------------------------------------------
    // Command and burst state
    // ------------------------------------------------------------------
    always_comb begin
        st_next       = st_reg;
        push          = 1'b0;
        push_word     = '0;
        ap_start      = 1'b0;
        ap_start_bank = st_reg.bank;

        if (st_reg.ap_run) begin
            if (st_reg.ap_cnt == 4'h1) begin
                st_next.open[st_reg.ap_bank] = 1'b0;
                st_next.ap_run               = 1'b0;
            end else begin
                st_next.ap_cnt = st_reg.ap_cnt - 4'h1;
            end
        end

        if (st_reg.act) begin
            unique case (cmd)
                `SDWP_CMD_WRITE, `SDWP_CMD_READ: begin
                    // Truncated burst: recovery starts at the new command.
                    st_next.act = 1'b0;
                    ap_start    = st_reg.ap;
                end
                `SDWP_CMD_TERM: begin
                    st_next.act = 1'b0;
                end
                `SDWP_CMD_PRE: begin
                    st_next.act = 1'b0;
                end
                default: begin
                    if (!link.dqm) begin
                        push      = 1'b1;
                        push_word = {st_reg.bank, st_reg.row[st_reg.bank], st_reg.col, link.dq};
                    end
                    st_next.col  = next_col(st_reg.col, st_reg.bl, st_reg.full);
                    st_next.left = st_reg.left - 1'b1;
                    if (!st_reg.full && st_reg.left == (`SDWP_COL_W+1)'(1)) begin
                        st_next.act = 1'b0;
                        ap_start    = st_reg.ap;
                    end
                end
            endcase
        end

        unique case (cmd)
            `SDWP_CMD_MODE: begin
                st_next.bl  = link.addr[`SDWP_BL_MSB:`SDWP_BL_LSB];
                st_next.wbm = link.addr[`SDWP_WBM_BIT];
            end
            `SDWP_CMD_ACT: begin
                st_next.open[ba] = 1'b1;
                st_next.row[ba]  = link.addr;
            end
            `SDWP_CMD_WRITE: begin
                if (st_reg.open[ba]) begin
                    if (!link.dqm) begin
                        push      = 1'b1;
                        push_word = {ba, st_reg.row[ba], link.addr[`SDWP_COL_W-1:0], link.dq};
                    end
                    st_next.bank = ba;
                    st_next.full = !st_reg.wbm && st_reg.bl == `SDWP_BL_FULL;
                    st_next.col  = next_col(link.addr[`SDWP_COL_W-1:0], st_reg.bl, st_next.full);
                    // Full-page length keeps the page open, in burst and single-column mode alike.
                    st_next.ap   = link.addr[`SDWP_AP_BIT] && st_reg.bl != `SDWP_BL_FULL;
                    if (st_reg.wbm || st_reg.bl == 3'h0) begin
                        st_next.act = 1'b0;
                        if (st_next.ap) begin
                            ap_start      = 1'b1;
                            ap_start_bank = ba;
                        end
                    end else begin
                        st_next.act  = 1'b1;
                        st_next.left = burst_len(st_reg.bl) - 1'b1;
                    end
                end
            end
            `SDWP_CMD_PRE: begin
                if (link.addr[`SDWP_AP_BIT]) begin
                    st_next.open = 4'h0;
                end else begin
                    st_next.open[ba] = 1'b0;
                end
            end
            default: begin
            end
        endcase

        if (ap_start) begin
            st_next.ap_run  = 1'b1;
            st_next.ap_bank = ap_start_bank;
            st_next.ap_cnt  = 4'(`SDWP_WR_CYC < 1 ? 1 : `SDWP_WR_CYC);
        end

        if (push && !fifo_ready) begin
            push         = 1'b0;
            st_next.drop = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule : sdwp_dev

// ### src/sdwp_host.sv
// Controller end: issues commands and keeps per-bank timing.
`include "sdwp_params.svh"
module sdwp_host (
    input  wire logic                 clk,
    input  wire logic                 rst,
    sdwp_link_if.host                 link,
    input  wire logic                 req_valid,
    input  wire sdwp_pkg::sdwp_op_t   req_op,
    input  wire logic [1:0]           req_bank,
    input  wire logic [11:0]          req_addr,
    input  wire logic                 req_all,
    input  wire logic                 req_ap,
    input  wire logic [15:0]          wr_data,
    input  wire logic                 wr_mask,
    output logic                      req_ready,
    output logic                      req_refused
);
    typedef struct packed {
        logic                cs_n;
        logic [2:0]          cmd_n;
        logic [11:0]         addr;
        logic [1:0]          ba;
        logic                dqm;
        logic [15:0]         dq;
        logic                oe_n;
        logic                ready;
        logic                refused;
        logic                hold;
        logic [3:0]          open;
        logic [3:0][4:0]     busy;
        logic [3:0][3:0]     rec;
        logic [2:0]          bl;
        logic                wbm;
        logic [9:0]          left;
        logic [1:0]          wbank;
    } sdwp_host_st_t;

    sdwp_host_st_t st_reg;
    sdwp_host_st_t st_next;
    logic          legal;
    logic          take;
    logic          pre_ok;

    assign link.cs_n           = st_reg.cs_n;
    assign link.cmd_n          = st_reg.cmd_n;
    assign link.addr           = st_reg.addr;
    assign link.bank_select_lo = st_reg.ba[0];
    assign link.bank_select_hi = st_reg.ba[1];
    assign link.dqm            = st_reg.dqm;
    assign link.dq_host_out    = st_reg.dq;
    assign link.dq_host_oe_n   = st_reg.oe_n;
    assign req_ready           = st_reg.ready;
    assign req_refused         = st_reg.refused;

    always_comb begin
        st_next         = st_reg;
        st_next.cs_n    = 1'b0;
        st_next.cmd_n   = `SDWP_CMD_NOP;
        st_next.dqm     = wr_mask;
        st_next.dq      = wr_data;
        st_next.oe_n    = 1'b0;
        st_next.refused = 1'b0;
        st_next.ready   = 1'b1;
        for (int b = 0; b < 4; b++) begin
            if (st_reg.busy[b] != 5'h00) begin
                st_next.busy[b] = st_reg.busy[b] - 5'h01;
            end
            if (st_reg.rec[b] != 4'h0) begin
                st_next.rec[b] = st_reg.rec[b] - 4'h1;
            end
        end
        // Reload recovery while a burst still moves data into its bank.
        if (st_reg.left != 10'h000) begin
            st_next.left             = st_reg.left - 10'h001;
            st_next.rec[st_reg.wbank] = 4'(`SDWP_WR_CYC - 1);
        end

        pre_ok = req_all ? (st_next.rec == '0) : (st_next.rec[req_bank] == 4'h0);
        unique case (req_op)
            sdwp_pkg::SDWP_OP_ACT:   legal = !st_reg.open[req_bank];
            sdwp_pkg::SDWP_OP_WRITE,
            sdwp_pkg::SDWP_OP_READ:  legal = st_reg.open[req_bank];
            sdwp_pkg::SDWP_OP_PRE:   legal = pre_ok;
            default:                 legal = 1'b1;
        endcase
        legal = legal && st_reg.busy[req_bank] == 5'h00;
        take  = req_valid && st_reg.ready && legal;
        st_next.refused = req_valid && st_reg.ready && !legal;

        if (st_reg.hold) begin
            st_next.hold  = 1'b0;
            st_next.cmd_n = `SDWP_CMD_PRE;
            st_next.dqm   = 1'b1;
        end else if (take) begin
            st_next.addr = req_addr;
            st_next.ba   = req_bank;
            unique case (req_op)
                sdwp_pkg::SDWP_OP_ACT: begin
                    st_next.cmd_n          = `SDWP_CMD_ACT;
                    st_next.open[req_bank] = 1'b1;
                end
                sdwp_pkg::SDWP_OP_WRITE, sdwp_pkg::SDWP_OP_READ: begin
                    st_next.cmd_n = req_op == sdwp_pkg::SDWP_OP_WRITE
                                    ? `SDWP_CMD_WRITE : `SDWP_CMD_READ;
                    st_next.addr[`SDWP_AP_BIT] = req_ap;
                    st_next.left = (req_op == sdwp_pkg::SDWP_OP_READ || st_reg.wbm)
                                   ? 10'h000 : 10'(11'h001 << st_reg.bl);
                    st_next.wbank          = req_bank;
                    st_next.rec[req_bank]  = 4'(`SDWP_WR_CYC);
                    if (req_ap && st_reg.bl != `SDWP_BL_FULL) begin
                        // Bank closes by itself; block it until it is idle again.
                        st_next.open[req_bank] = 1'b0;
                        st_next.busy[req_bank] = 5'(`SDWP_AP_WAIT + `SDWP_WR_CYC + `SDWP_RP_CYC);
                        st_next.left           = 10'h000;
                    end
                end
                sdwp_pkg::SDWP_OP_PRE: begin
                    st_next.addr[`SDWP_AP_BIT] = req_all;
                    st_next.left               = 10'h000;
                    for (int b = 0; b < 4; b++) begin
                        if (req_all || req_bank == 2'(b)) begin
                            st_next.open[b] = 1'b0;
                            st_next.busy[b] = 5'(`SDWP_RP_CYC);
                        end
                    end
                    if (`SDWP_MASK_NEED) begin
                        // Spend one masked NOP so the edge before the precharge is masked.
                        st_next.hold  = 1'b1;
                        st_next.ready = 1'b0;
                        st_next.dqm   = 1'b1;
                    end else begin
                        st_next.cmd_n = `SDWP_CMD_PRE;
                    end
                end
                sdwp_pkg::SDWP_OP_TERM: begin
                    st_next.cmd_n = `SDWP_CMD_TERM;
                    st_next.left  = 10'h000;
                end
                default: begin
                    st_next.cmd_n = `SDWP_CMD_MODE;
                    st_next.bl    = req_addr[`SDWP_BL_MSB:`SDWP_BL_LSB];
                    st_next.wbm   = req_addr[`SDWP_WBM_BIT];
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg       <= '0;
            st_reg.cs_n  <= 1'b1;
            st_reg.cmd_n <= `SDWP_CMD_NOP;
            st_reg.oe_n  <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule : sdwp_host

// ### sim/sdwp_link_checker.sv
// Concurrent checks on the link between the controller end and the SDRAM end.
`include "sdwp_params.svh"
module sdwp_link_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        cs_n,
    input wire logic [2:0]  cmd_n,
    input wire logic [11:0] addr,
    input wire logic        bank_select_lo,
    input wire logic        bank_select_hi,
    input wire logic        dq_host_oe_n,
    input wire logic        dq_dev_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Bank tracking
    // ----------------------------------------
    logic [1:0] bk;
    logic       is_act;
    logic       is_wr;
    logic       is_rd;
    logic       is_pre;
    logic       bank_cmd;
    logic [3:0] open_reg;
    assign bk = {bank_select_hi, bank_select_lo};
    assign is_act = !cs_n && cmd_n == `SDWP_CMD_ACT;
    assign is_wr = !cs_n && cmd_n == `SDWP_CMD_WRITE;
    assign is_rd = !cs_n && cmd_n == `SDWP_CMD_READ;
    assign is_pre = !cs_n && cmd_n == `SDWP_CMD_PRE;
    assign bank_cmd = is_act || is_wr || is_rd || is_pre;
    // Auto precharge closes the bank at once; full-page bursts with it are not followed.
    always_ff @(posedge clk) begin
        if (rst) begin
            open_reg <= 4'h0;
        end else if (is_act) begin
            open_reg[bk] <= 1'h1;
        end else if (is_pre && addr[`SDWP_AP_BIT]) begin
            open_reg <= 4'h0;
        end else if (is_pre || ((is_wr || is_rd) && addr[`SDWP_AP_BIT])) begin
            open_reg[bk] <= 1'h0;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_ap_write; is_wr && addr[`SDWP_AP_BIT]; endsequence
    sequence s_same_bank_cmd; bank_cmd && bk == $past(bk); endsequence
    property p_ap_hold; s_ap_write |=> not s_same_bank_cmd; endproperty
    property p_dev_quiet; dq_dev_oe_n; endproperty
    property p_wr_data; is_wr |-> !dq_host_oe_n; endproperty
    property p_wr_burst; is_wr |=> !dq_host_oe_n; endproperty
    property p_wr_open; is_wr |-> open_reg[bk]; endproperty
    property p_rd_open; is_rd |-> open_reg[bk]; endproperty
    property p_act_idle; is_act |-> !open_reg[bk]; endproperty
    property p_rst_idle; $fell(rst) |-> cs_n && dq_host_oe_n; endproperty
    a_ap_hold: assert property (p_ap_hold) else $error("bank used during recovery");
    a_dev_quiet: assert property (p_dev_quiet) else $error("device drove data");
    a_wr_data: assert property (p_wr_data) else $error("no data with write");
    a_wr_burst: assert property (p_wr_burst) else $error("no data after write");
    a_wr_open: assert property (p_wr_open) else $error("write to idle bank");
    a_rd_open: assert property (p_rd_open) else $error("read to idle bank");
    a_act_idle: assert property (p_act_idle) else $error("activate of open bank");
    a_rst_idle: assert property (p_rst_idle) else $error("link busy after reset");
    c_wr_b2b: cover property (is_wr ##1 is_wr);
endmodule : sdwp_link_checker

// ### sim/sdram_write_precharge_path_bench.sv
// Self-checking bench joining the controller end to the SDRAM end.
module sdram_write_precharge_path_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk;
    logic               rst;
    logic               req_valid;
    sdwp_pkg::sdwp_op_t req_op;
    logic [1:0]         req_bank;
    logic [11:0]        req_addr;
    logic               req_all;
    logic               req_ap;
    logic [15:0]        wr_data;
    logic               wr_mask;
    logic               req_ready;
    logic               req_refused;
    logic               store_valid;
    logic               store_ready;
    logic [38:0]        store_word;
    logic [3:0]         bank_open;
    logic               burst_busy;
    logic               store_dropped;
    logic [38:0]        exp_q[$];
    logic [38:0]        got_q[$];
    logic [11:0]        rows[4];
    int                 miscompares;
    int                 compares;
    sdwp_link_if sdwp_link_if_inst (.clk(clk));
    sdwp_host sdwp_host_inst (.clk(clk), .rst(rst), .link(sdwp_link_if_inst),
        .req_valid(req_valid), .req_op(req_op), .req_bank(req_bank), .req_addr(req_addr),
        .req_all(req_all), .req_ap(req_ap), .wr_data(wr_data), .wr_mask(wr_mask),
        .req_ready(req_ready), .req_refused(req_refused));
    sdwp_dev sdwp_dev_inst (.clk(clk), .rst(rst), .link(sdwp_link_if_inst),
        .store_valid(store_valid), .store_ready(store_ready), .store_word(store_word),
        .bank_open(bank_open), .burst_busy(burst_busy), .store_dropped(store_dropped));
    sdwp_link_checker sdwp_link_checker_inst (.clk(clk), .rst(rst),
        .cs_n(sdwp_link_if_inst.cs_n), .cmd_n(sdwp_link_if_inst.cmd_n),
        .addr(sdwp_link_if_inst.addr), .bank_select_lo(sdwp_link_if_inst.bank_select_lo),
        .bank_select_hi(sdwp_link_if_inst.bank_select_hi),
        .dq_host_oe_n(sdwp_link_if_inst.dq_host_oe_n),
        .dq_dev_oe_n(sdwp_link_if_inst.dq_dev_oe_n));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(logic [38:0] got, logic [38:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report();
        if (miscompares == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    // One request; an accepted unmasked write is expected at its column.
    task automatic rq(sdwp_pkg::sdwp_op_t op, logic [1:0] b, logic [11:0] a,
                      logic ap = 1'h0, logic [15:0] d = 16'hdead, logic m = 1'h0,
                      logic rf = 1'h0);
        if (op == sdwp_pkg::SDWP_OP_ACT) rows[b] = a;
        req_valid <= 1'h1;
        req_op <= op;
        req_bank <= b;
        req_addr <= a;
        req_all <= ap && op == sdwp_pkg::SDWP_OP_PRE;
        req_ap <= ap && op != sdwp_pkg::SDWP_OP_PRE;
        wr_data <= d;
        wr_mask <= m;
        @(negedge clk);
        for (int n = 0; n < 40 && req_ready !== 1'h1; n++) @(negedge clk);
        @(posedge clk);
        if (op == sdwp_pkg::SDWP_OP_WRITE && !rf && !m) exp_q.push_back({b, rows[b], a[8:0], d});
        fork
            begin
                @(negedge clk);
                chk({38'h0, req_refused}, {38'h0, rf});
            end
        join_none
    endtask : rq
    task automatic dt(logic [15:0] d = 16'hdead, logic m = 1'h0);
        req_valid <= 1'h0;
        wr_data <= d;
        wr_mask <= m;
        @(posedge clk);
    endtask : dt
    task automatic de(logic [1:0] b, logic [8:0] c, logic [15:0] d);
        exp_q.push_back({b, rows[b], c, d});
        dt(d);
    endtask : de
    // ----------------------------------------
    // Clock, monitor, watchdog and tests
    // ----------------------------------------
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) if (!rst && store_valid === 1'h1 && store_ready === 1'h1) got_q.push_back(store_word);
    initial begin
        #200_000;
        miscompares++;
        final_report();
    end
    initial begin
        {rst, store_ready} = 2'h3;
        {req_valid, req_all, req_ap, wr_mask} = 4'h0;
        {req_bank, req_addr, wr_data} = 30'h0;
        req_op = sdwp_pkg::SDWP_OP_MODE;
        miscompares = 0;
        compares = 0;
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        rq(sdwp_pkg::SDWP_OP_MODE, 2'h0, 12'h001);
        rq(sdwp_pkg::SDWP_OP_ACT, 2'h0, 12'h0a5);
        rq(sdwp_pkg::SDWP_OP_WRITE, 2'h0, 12'h004, 1'h0, 16'h1111);
        de(2'h0, 9'h005, 16'h2222);
        dt();
        rq(sdwp_pkg::SDWP_OP_WRITE, 2'h0, 12'h008, 1'h0, 16'h3333);
        rq(sdwp_pkg::SDWP_OP_WRITE, 2'h0, 12'h010, 1'h0, 16'h4444);
        de(2'h0, 9'h011, 16'h5555);
        rq(sdwp_pkg::SDWP_OP_MODE, 2'h0, 12'h201);
        rq(sdwp_pkg::SDWP_OP_ACT, 2'h1, 12'h003);
        rq(sdwp_pkg::SDWP_OP_WRITE, 2'h0, 12'h01e, 1'h0, 16'h6666);
        rq(sdwp_pkg::SDWP_OP_WRITE, 2'h1, 12'h01f, 1'h0, 16'h7777);
        rq(sdwp_pkg::SDWP_OP_MODE, 2'h0, 12'h001);
        rq(sdwp_pkg::SDWP_OP_WRITE, 2'h0, 12'h028, 1'h0, 16'h8888);
        rq(sdwp_pkg::SDWP_OP_READ, 2'h0, 12'h028);
        rq(sdwp_pkg::SDWP_OP_MODE, 2'h0, 12'h003);
        rq(sdwp_pkg::SDWP_OP_WRITE, 2'h1, 12'h032, 1'h0, 16'h9999);
        dt(16'haaaa, 1'h1);
        de(2'h1, 9'h034, 16'hbbbb);
        rq(sdwp_pkg::SDWP_OP_TERM, 2'h1, 12'h000);
        rq(sdwp_pkg::SDWP_OP_MODE, 2'h0, 12'h007);
        rq(sdwp_pkg::SDWP_OP_WRITE, 2'h1, 12'h1fe, 1'h0, 16'hc001);
        de(2'h1, 9'h1ff, 16'hc002);
        de(2'h1, 9'h000, 16'hc003);
        chk({38'h0, burst_busy}, 39'h1);
        rq(sdwp_pkg::SDWP_OP_PRE, 2'h1, 12'h000);
        repeat (3) dt();
        chk({35'h0, bank_open}, 39'h1);
        rq(sdwp_pkg::SDWP_OP_WRITE, 2'h1, 12'h000, 1'h0, 16'hdead, 1'h0, 1'h1);
        rq(sdwp_pkg::SDWP_OP_ACT, 2'h1, 12'h004);
        rq(sdwp_pkg::SDWP_OP_PRE, 2'h0, 12'h000, 1'h1);
        repeat (3) dt();
        chk({35'h0, bank_open}, 39'h0);
        rq(sdwp_pkg::SDWP_OP_MODE, 2'h0, 12'h000);
        rq(sdwp_pkg::SDWP_OP_ACT, 2'h2, 12'h0c3);
        rq(sdwp_pkg::SDWP_OP_WRITE, 2'h2, 12'h03c, 1'h1, 16'hd00d);
        rq(sdwp_pkg::SDWP_OP_WRITE, 2'h2, 12'h03d, 1'h0, 16'hdead, 1'h0, 1'h1);
        repeat (3) dt();
        chk({35'h0, bank_open}, 39'h0);
        repeat (12) dt();
        rq(sdwp_pkg::SDWP_OP_ACT, 2'h2, 12'h0c4);
        rq(sdwp_pkg::SDWP_OP_WRITE, 2'h2, 12'h03e, 1'h0, 16'he00e);
        repeat (4) dt();
        chk({35'h0, bank_open}, 39'h4);
        // Stall the store side so the fifth word is dropped.
        store_ready <= 1'h0;
        for (int i = 0; i < 5; i++) begin
            rq(sdwp_pkg::SDWP_OP_WRITE, 2'h2, 12'h040 + 12'(i), 1'h0, 16'hf000 + 16'(i));
        end
        void'(exp_q.pop_back());
        repeat (3) dt();
        chk({38'h0, store_dropped}, 39'h1);
        store_ready <= 1'h1;
        repeat (8) dt();
        chk({38'h0, store_valid}, 39'h0);
        chk(39'(got_q.size()), 39'(exp_q.size()));
        foreach (exp_q[i]) if (i < got_q.size()) chk(got_q[i], exp_q[i]);
        rst <= 1'h1;
        repeat (2) dt();
        rst <= 1'h0;
        dt();
        chk({34'h0, store_dropped, bank_open}, 39'h0);
        final_report();
    end
endmodule : sdram_write_precharge_path_bench
